/* src/charger_control.v */
`timescale 1ns/1ps
`include "charger_map.vh"
module charger_control
#(
   parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYC,
   parameter FAULT_LIMIT = `FAULT_LIMIT,
   parameter BLINK_CYCLES = `BLINK_CYC
)
(
   input wire core_clk_in,
   input wire rst_b_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   output reg [7:0] reg_rdata_out,
   input wire vbus_present_in,
   input wire wall_present_in,
   input wire dminus_logic_in,
   input wire dline_short_in,
   input wire input_low_in,
   input wire supply_fault_in,
   input wire battery_ok_in,
   input wire [7:0] die_temp_in,
   input wire die_temp_valid_in,
   input wire [2:0] adc_channel_in,
   input wire [7:0] adc_value_in,
   input wire adc_valid_in,
   input wire emerg_blink_en_in,
   output reg dplus_drive_out,
   output reg settings_load_out,
   output reg buck_enable_out,
   output reg buck_low_power_out,
   output reg [3:0] buck_current_limit_out,
   output reg charge_enable_out,
   output reg [5:0] charge_current_out,
   output reg [1:0] precharge_current_out,
   output reg [4:0] charge_target_voltage_out,
   output reg [2:0] input_low_voltage_threshold_out,
   output reg emergency_charge_out,
   output reg auto_boot_block_out,
   output reg indicator_output_a_out,
   output reg indicator_output_b_out
);

   localparam ST_IDLE = 3'h0;
   localparam ST_DEBOUNCE = 3'h1;
   localparam ST_DETECT = 3'h2;
   localparam ST_DONE = 3'h3;

   reg [7:0] buck_ctrl_r;
   reg [7:0] in_limits_r;
   reg [7:0] bat_curr_r;
   reg [7:0] chg_volt_r;
   reg [7:0] battery_temp_reading_stop_r;
   reg [7:0] battery_temp_reading_resume_r;
   reg [7:0] battery_temp_low_level_r;
   reg [7:0] battery_temp_reading_r;
   reg battery_temp_reading_seen_r;
   reg [2:0] det_state_r;
   reg [2:0] det_state_nxt;
   reg [23:0] deb_cnt_r;
   reg dedicated_r;
   reg det_load_r;
   reg [3:0] target_limit;
   reg [3:0] ramp_r;
   reg [15:0] ramp_cnt_r;
   reg bat_hot_r;
   reg [3:0] fault_cnt_r;
   reg fault_d_r;
   reg [23:0] blink_cnt_r;
   reg blink_r;
   wire [2:0] die_class;
   wire [5:0] die_cap;
   wire therm_en;
   wire no_source;
   wire bat_ok;
   wire [5:0] cc_code;
   reg [7:0] rdata;

   assign therm_en = buck_ctrl_r[`BIT_THERM_EN];
   assign no_source = !vbus_present_in && !wall_present_in;

   function [5:0] min6;
      input [5:0] a;
      input [5:0] b;
      begin
         min6 = (a < b) ? a : b;
      end
   endfunction

   die_temp_class u_die_class
   (
      .core_clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .enable_in(therm_en),
      .temp_valid_in(die_temp_valid_in),
      .die_temp_in(die_temp_in),
      .class_out(die_class),
      .cap_out(die_cap)
   );

   ////////////////////////////////////////////////////////////////////////////
   // register file
   always @(posedge core_clk_in)
   begin
      if (!rst_b_in)
      begin
         buck_ctrl_r <= `RST_BUCK_CTRL;
         in_limits_r <= `RST_IN_LIMITS;
         bat_curr_r <= `RST_BAT_CURR;
         chg_volt_r <= `RST_CHG_VOLT;
         battery_temp_reading_stop_r <= `RST_BATTERY_TEMP_READING_STOP;
         battery_temp_reading_resume_r <= `RST_BATTERY_TEMP_READING_RESUME;
         battery_temp_low_level_r <= `RST_BATTERY_TEMP_LOW_LEVEL;
      end
      else
      begin
         // hardware limit loads win over a same-cycle software write to 3:0
         if (reg_wr_in)
         begin
            case (reg_addr_in)
               `ADDR_BUCK_CTRL: buck_ctrl_r <= reg_wdata_in;
               `ADDR_IN_LIMITS: in_limits_r <= reg_wdata_in;
               `ADDR_BAT_CURR: bat_curr_r <= reg_wdata_in;
               `ADDR_CHG_VOLT: chg_volt_r <= reg_wdata_in;
               `ADDR_BATTERY_TEMP_READING_STOP: battery_temp_reading_stop_r <= reg_wdata_in;
               `ADDR_BATTERY_TEMP_READING_RESUME: battery_temp_reading_resume_r <= reg_wdata_in;
               `ADDR_BATTERY_TEMP_LOW_LEVEL: battery_temp_low_level_r <= reg_wdata_in;
               default: ;
            endcase
         end
         if (wall_present_in && !(reg_wr_in && reg_addr_in == `ADDR_IN_LIMITS))
            buck_ctrl_r[3:0] <= in_limits_r[7:4];
         else if (wall_present_in)
            buck_ctrl_r[3:0] <= reg_wdata_in[7:4];
         else if (vbus_present_in && !buck_ctrl_r[`BIT_AUTODET] && dminus_logic_in)
            buck_ctrl_r[3:0] <= in_limits_r[3:0];
         else if (det_load_r && dedicated_r)
            buck_ctrl_r[3:0] <= in_limits_r[3:0];
      end
   end

   always @*
   begin
      case (reg_addr_in)
         `ADDR_BUCK_CTRL: rdata = buck_ctrl_r;
         `ADDR_IN_LIMITS: rdata = in_limits_r;
         `ADDR_BAT_CURR: rdata = bat_curr_r;
         `ADDR_CHG_VOLT: rdata = chg_volt_r;
         `ADDR_BATTERY_TEMP_READING_STOP: rdata = battery_temp_reading_stop_r;
         `ADDR_BATTERY_TEMP_READING_RESUME: rdata = battery_temp_reading_resume_r;
         `ADDR_BATTERY_TEMP_LOW_LEVEL: rdata = battery_temp_low_level_r;
         default: rdata = 8'h00;
      endcase
   end

   always @(posedge core_clk_in)
   begin
      if (!rst_b_in)
         reg_rdata_out <= 8'h00;
      else if (reg_rd_in)
         reg_rdata_out <= rdata;
   end

   ////////////////////////////////////////////////////////////////////////////
   // vbus attach debounce and line detection
   always @*
   begin
      det_state_nxt = det_state_r;
      case (det_state_r)
         ST_IDLE:
            if (vbus_present_in && buck_ctrl_r[`BIT_AUTODET])
               det_state_nxt = ST_DEBOUNCE;
         ST_DEBOUNCE:
            if (!vbus_present_in)
               det_state_nxt = ST_IDLE;
            else if (deb_cnt_r == DEBOUNCE_CYCLES - 1)
               det_state_nxt = ST_DETECT;
         ST_DETECT:
            det_state_nxt = ST_DONE;
         ST_DONE:
            if (!vbus_present_in)
               det_state_nxt = ST_IDLE;
         default:
            det_state_nxt = ST_IDLE;
      endcase
   end

   always @(posedge core_clk_in)
   begin
      if (!rst_b_in)
      begin
         det_state_r <= ST_IDLE;
         deb_cnt_r <= 24'h000000;
         dedicated_r <= 1'b0;
         det_load_r <= 1'b0;
         dplus_drive_out <= 1'b0;
         settings_load_out <= 1'b0;
      end
      else
      begin
         det_state_r <= det_state_nxt;
         deb_cnt_r <= (det_state_r == ST_DEBOUNCE) ? deb_cnt_r + 24'h000001 : 24'h000000;
         // d+ is driven through the detect cycle; the short only reads while driven
         dplus_drive_out <= (det_state_nxt == ST_DETECT);
         settings_load_out <= (det_state_nxt == ST_DETECT);
         // one-shot load, so a later software limit write is not overwritten
         det_load_r <= (det_state_r == ST_DETECT);
         if (det_state_r == ST_DETECT)
            dedicated_r <= dline_short_in;
         else if (det_state_nxt == ST_IDLE)
            dedicated_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input collapse: step limit down, then back to programmed value
   always @*
   begin
      target_limit = buck_ctrl_r[3:0];
   end

   always @(posedge core_clk_in)
   begin
      if (!rst_b_in)
      begin
         ramp_r <= 4'h0;
         ramp_cnt_r <= 16'h0000;
      end
      else if (ramp_cnt_r != `RAMP_STEP_CYC - 16'h0001)
         ramp_cnt_r <= ramp_cnt_r + 16'h0001;
      else
      begin
         ramp_cnt_r <= 16'h0000;
         if (input_low_in && ramp_r != 4'h0)
            ramp_r <= ramp_r - 4'h1;
         else if (!input_low_in && ramp_r < target_limit)
            ramp_r <= ramp_r + 4'h1;
         // a lowered limit is also walked down, never jumped
         else if (!input_low_in && ramp_r > target_limit)
            ramp_r <= ramp_r - 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // battery thermistor qualification
   always @(posedge core_clk_in)
   begin
      if (!rst_b_in)
      begin
         battery_temp_reading_r <= 8'h00;
         battery_temp_reading_seen_r <= 1'b0;
         bat_hot_r <= 1'b0;
      end
      else if (adc_valid_in && adc_channel_in == `ADC_CH_BATTERY_TEMP_READING)
      begin
         battery_temp_reading_r <= adc_value_in;
         battery_temp_reading_seen_r <= 1'b1;
         if (adc_value_in > battery_temp_reading_stop_r)
            bat_hot_r <= 1'b1;
         else if (adc_value_in <= battery_temp_reading_resume_r)
            bat_hot_r <= 1'b0;
      end
   end

   // no charging until a first reading has qualified the pack
   assign bat_ok = battery_temp_reading_seen_r && !bat_hot_r && (battery_temp_reading_r >= battery_temp_low_level_r);
   assign cc_code = therm_en ? min6(bat_curr_r[5:0], die_cap) : bat_curr_r[5:0];

   ////////////////////////////////////////////////////////////////////////////
   // emergency charge against supply-fault reboot loops
   always @(posedge core_clk_in)
   begin
      if (!rst_b_in)
      begin
         fault_d_r <= 1'b0;
         fault_cnt_r <= 4'h0;
         emergency_charge_out <= 1'b0;
         auto_boot_block_out <= 1'b0;
         blink_cnt_r <= 24'h000000;
         blink_r <= 1'b0;
      end
      else
      begin
         fault_d_r <= supply_fault_in;
         if (no_source)
            fault_cnt_r <= 4'h0;
         else if (supply_fault_in && !fault_d_r && fault_cnt_r != 4'hF)
            fault_cnt_r <= fault_cnt_r + 4'h1;
         // limitation: only leaves once battery is good or supply goes away
         if (fault_cnt_r >= FAULT_LIMIT[3:0] && !battery_ok_in)
            emergency_charge_out <= 1'b1;
         else if (battery_ok_in || no_source)
            emergency_charge_out <= 1'b0;
         auto_boot_block_out <= emergency_charge_out;
         // blink runs only in emergency charge, starting from a known phase
         if (!emergency_charge_out)
         begin
            blink_cnt_r <= 24'h000000;
            blink_r <= 1'b0;
         end
         else if (blink_cnt_r == BLINK_CYCLES - 1)
         begin
            blink_cnt_r <= 24'h000000;
            blink_r <= ~blink_r;
         end
         else
            blink_cnt_r <= blink_cnt_r + 24'h000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   always @(posedge core_clk_in)
   begin
      if (!rst_b_in)
      begin
         buck_enable_out <= 1'b0;
         buck_low_power_out <= 1'b0;
         buck_current_limit_out <= 4'h0;
         charge_enable_out <= 1'b0;
         charge_current_out <= 6'h00;
         precharge_current_out <= 2'h0;
         charge_target_voltage_out <= 5'h00;
         input_low_voltage_threshold_out <= 3'h0;
         indicator_output_a_out <= 1'b0;
         indicator_output_b_out <= 1'b0;
      end
      else
      begin
         buck_enable_out <= buck_ctrl_r[`BIT_BUCK_EN];
         buck_low_power_out <= buck_ctrl_r[`BIT_LOW_POWER];
         buck_current_limit_out <= ramp_r;
         charge_enable_out <= bat_ok && (cc_code != 6'h00);
         charge_current_out <= bat_ok ? cc_code : 6'h00;
         precharge_current_out <= bat_curr_r[7:6];
         charge_target_voltage_out <= chg_volt_r[7:3];
         input_low_voltage_threshold_out <= chg_volt_r[2:0];
         indicator_output_a_out <= emergency_charge_out && emerg_blink_en_in && blink_r;
         indicator_output_b_out <= emergency_charge_out && emerg_blink_en_in && !blink_r;
      end
   end
endmodule

/* src/charger_map.vh */
`ifndef CHARGER_MAP_VH
`define CHARGER_MAP_VH
// What this block does
// - control bit 6 picks automatic D+/D- detection or fixed limit selection
// - without autodetect, load wall or usb limit by source; wall wins if both
// - d-minus logic select: high picks usb limit, low keeps buck limit
// - on vbus attach with autodetect, wait 10 ms debounce before settings load
// - after debounce drive detection; shorted lines mean dedicated charger
// - dedicated charger loads usb limit; standard port keeps programmed limit
// - repeated supply-fault resets enter emergency charge, auto boot held off
// - two indicator outputs may blink while emergency charge is active
// - bit 7 enables thermal current control; clear disables it
// - die temperature classes 0..6 cap charge current code per table
// - class only drops back after temperature falls below class 1 threshold
// - suspend above 115 degrees, begin reducing above 90 degrees
// - battery temperature from adc channel 2 checked before charging starts
// - stop charging when battery reading exceeds stop level
// - after stop, resume only once reading drops to resume level
// - do not start charging while reading is below low level
// - bit 5 puts buck into low-power sleep mode
// - bit 4 enables buck; bits 3:0 hold buck current limit
// - wall presence copies wall limit bits 7:4 into buck limit
// - charge register: precharge bits 7:6, cc current bits 5:0
// - control register: target voltage bits 7:3, input threshold bits 2:0
// - input below threshold steps limit down to minimum, then back up
`define ADDR_BUCK_CTRL 8'h3E
`define ADDR_IN_LIMITS 8'h40
`define ADDR_BAT_CURR 8'h41
`define ADDR_CHG_VOLT 8'h42
`define ADDR_BATTERY_TEMP_READING_STOP 8'h5B
`define ADDR_BATTERY_TEMP_READING_RESUME 8'h5C
`define ADDR_BATTERY_TEMP_LOW_LEVEL 8'h5D
`define BIT_THERM_EN 7
`define BIT_AUTODET 6
`define BIT_LOW_POWER 5
`define BIT_BUCK_EN 4
`define RST_BUCK_CTRL 8'hD1
`define RST_IN_LIMITS 8'h00
`define RST_BAT_CURR 8'h3F
`define RST_CHG_VOLT 8'h00
`define RST_BATTERY_TEMP_READING_STOP 8'hFF
`define RST_BATTERY_TEMP_READING_RESUME 8'hFF
`define RST_BATTERY_TEMP_LOW_LEVEL 8'h00
`define ADC_CH_BATTERY_TEMP_READING 3'h2
`define CLK_HZ 10000000
`define DEBOUNCE_MS 10
`define DEBOUNCE_CYC ((`CLK_HZ / 1000) * `DEBOUNCE_MS)
`define RAMP_STEP_CYC 16'h03E8
`define FAULT_LIMIT 4'h4
`define BLINK_CYC 24'h4C4B40
`define DIE_T1 8'h5A
`define DIE_T2 8'h5F
`define DIE_T3 8'h64
`define DIE_T4 8'h69
`define DIE_T5 8'h6E
`define DIE_T6 8'h73
`define DIE_SUSPEND 8'h78
`endif

/* src/die_temp_class.v */
`timescale 1ns/1ps
module die_temp_class
(
   input wire core_clk_in,
   input wire rst_b_in,
   input wire enable_in,
   input wire temp_valid_in,
   input wire [7:0] die_temp_in,
   output reg [2:0] class_out,
   output reg [5:0] cap_out
);
`include "charger_map.vh"

   reg [2:0] raw;

   function [5:0] cap_of;
      input [2:0] c;
      begin
         case (c)
            3'h0: cap_of = 6'h3F;
            3'h1: cap_of = 6'h37;
            3'h2: cap_of = 6'h2D;
            3'h3: cap_of = 6'h23;
            3'h4: cap_of = 6'h19;
            3'h5: cap_of = 6'h0F;
            default: cap_of = 6'h00;
         endcase
      end
   endfunction

   always @*
   begin
      raw = 3'h0;
      if (die_temp_in >= `DIE_SUSPEND)
         raw = 3'h6;
      else if (die_temp_in > `DIE_T6)
         raw = 3'h6;
      else if (die_temp_in > `DIE_T5)
         raw = 3'h5;
      else if (die_temp_in > `DIE_T4)
         raw = 3'h4;
      else if (die_temp_in > `DIE_T3)
         raw = 3'h3;
      else if (die_temp_in > `DIE_T2)
         raw = 3'h2;
      else if (die_temp_in > `DIE_T1)
         raw = 3'h1;
   end

   always @(posedge core_clk_in)
   begin
      if (!rst_b_in || !enable_in)
      begin
         class_out <= 3'h0;
         cap_out <= 6'h3F;
      end
      else if (temp_valid_in)
      begin
         // class only climbs; full release below class 1 stops hunting
         if (raw > class_out)
         begin
            class_out <= raw;
            cap_out <= cap_of(raw);
         end
         else if (die_temp_in < `DIE_T1)
         begin
            class_out <= 3'h0;
            cap_out <= 6'h3F;
         end
      end
   end
endmodule

/* tb/charger_control_properties.sv */
`timescale 1ns/1ps
module charger_control_checker
#(
   parameter DEBOUNCE_CYCLES = 20
)
(
   input wire core_clk_in,
   input wire rst_b_in,
   input wire reg_rd_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_rdata_out,
   input wire vbus_present_in,
   input wire dplus_drive_out,
   input wire settings_load_out,
   input wire [3:0] buck_current_limit_out,
   input wire emergency_charge_out,
   input wire auto_boot_block_out,
   input wire indicator_output_a_out,
   input wire indicator_output_b_out
);
default clocking cb @(posedge core_clk_in);
endclocking
default disable iff (!rst_b_in);
reg [31:0] vbus_cnt_r;
always @(posedge core_clk_in)
   if (!rst_b_in || !vbus_present_in)
      vbus_cnt_r <= 32'h0;
   else
      vbus_cnt_r <= vbus_cnt_r + 32'h1;
////////////////////////////////////////////////////////////////////////////////
a_debounce_wait: assert property (settings_load_out |-> vbus_cnt_r >= DEBOUNCE_CYCLES)
   else $error("settings load before debounce ran out");
a_load_pulse: assert property (settings_load_out |=> !settings_load_out)
   else $error("settings load longer than one cycle");
a_detect_drive: assert property (settings_load_out |-> dplus_drive_out)
   else $error("detect without line drive");
// guarded by past reset: a mid-run reset clears outputs at once
a_boot_block: assert property ($past(rst_b_in) |-> auto_boot_block_out == $past(emergency_charge_out))
   else $error("boot block does not follow emergency charge");
a_blink_excl: assert property (indicator_output_a_out |-> !indicator_output_b_out)
   else $error("indicators not in antiphase");
a_ramp_step: assert property ($past(rst_b_in) && $changed(buck_current_limit_out) |->
   buck_current_limit_out == $past(buck_current_limit_out) + 4'h1 ||
   buck_current_limit_out + 4'h1 == $past(buck_current_limit_out))
   else $error("buck limit jumped more than one step");
a_ramp_space: assert property ($past(rst_b_in) && $changed(buck_current_limit_out) |=>
   $stable(buck_current_limit_out) [*8])
   else $error("buck limit steps too close");
a_rdata_hold: assert property ($past(rst_b_in) && !$past(reg_rd_in) |-> $stable(reg_rdata_out))
   else $error("read data changed without a read");
a_unmapped_zero: assert property ($past(reg_rd_in) && !($past(reg_addr_in) inside
   {8'h3E, 8'h40, 8'h41, 8'h42, 8'h5B, 8'h5C, 8'h5D}) |-> reg_rdata_out == 8'h00)
   else $error("unmapped read not zero");
endmodule
bind charger_control charger_control_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES))
   charger_control_checker_i (.*);

/* tb/usb_source_model.sv */
`timescale 1ns/1ps
module usb_source_model
(
   input wire plug_in,
   input wire [1:0] kind_in,
   input wire dplus_in,
   output wire vbus_out,
   output wire dline_short_out,
   output wire dminus_out
);
// kind: 0 standard port, 1 dedicated charger, 2 phy logic select
assign vbus_out = plug_in;
// the short only shows while the device drives d+
assign dline_short_out = plug_in && kind_in == 2'h1 && dplus_in;
// d- pulled low once detached
assign dminus_out = plug_in && kind_in == 2'h2;
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
logic core_clk_in = 1'b0;
logic rst_b_in = 1'b0;
logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, wall_present_in = 1'b0, input_low_in = 1'b0;
logic supply_fault_in = 1'b0, battery_ok_in = 1'b0, die_temp_valid_in = 1'b0;
logic adc_valid_in = 1'b0, emerg_blink_en_in = 1'b0, plug = 1'b0;
logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, die_temp_in = 8'h00, adc_value_in = 8'h00;
logic [2:0] adc_channel_in = 3'h0;
logic [1:0] kind = 2'h0, seen;
wire vbus_present_in, dminus_logic_in, dline_short_in;
wire [7:0] reg_rdata_out;
wire [5:0] charge_current_out;
wire [4:0] charge_target_voltage_out;
wire [3:0] buck_current_limit_out;
wire [2:0] input_low_voltage_threshold_out;
wire [1:0] precharge_current_out;
wire dplus_drive_out, settings_load_out, buck_enable_out, buck_low_power_out;
wire charge_enable_out, emergency_charge_out, auto_boot_block_out;
wire indicator_output_a_out, indicator_output_b_out;
integer fail_count = 0, num_checks = 0, i, n;
// short debounce and blink keep the run brief
charger_control #(.DEBOUNCE_CYCLES(20), .FAULT_LIMIT(4), .BLINK_CYCLES(8)) charger_control_i (.*);
usb_source_model usb_source_model_i (.plug_in(plug), .kind_in(kind), .vbus_out(vbus_present_in),
   .dplus_in(dplus_drive_out), .dline_short_out(dline_short_in), .dminus_out(dminus_logic_in));
always #50 core_clk_in = ~core_clk_in;
////////////////////////////////////////////////////////////////////////////////
task tick(input integer k);
   repeat (k) @(posedge core_clk_in);
   #1;
endtask
task chk(input [7:0] got, input [7:0] exp);
   num_checks = num_checks + 1;
   if (got !== exp)
   begin
      fail_count = fail_count + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
   end
endtask
task chk1(input got, input exp);
   chk({7'h0, got}, {7'h0, exp});
endtask
// extra idle cycle so back-to-back calls never retoggle a strobe in one step
task wr(input [7:0] a, input [7:0] d);
   reg_addr_in = a;
   reg_wdata_in = d;
   reg_wr_in = 1'b1;
   tick(1);
   reg_wr_in = 1'b0;
   tick(1);
endtask
task rd(input [7:0] a, input [7:0] e);
   reg_addr_in = a;
   reg_rd_in = 1'b1;
   tick(1);
   reg_rd_in = 1'b0;
   tick(1);
   chk(reg_rdata_out, e);
endtask
task wait_lim(input [3:0] e);
   for (n = 0; n < 16000 && buck_current_limit_out !== e; n = n + 1)
      tick(1);
   chk({4'h0, buck_current_limit_out}, {4'h0, e});
endtask
task sample(input d, input [2:0] c, input [7:0] v);
   die_temp_in = v;
   adc_channel_in = c;
   adc_value_in = v;
   die_temp_valid_in = d;
   adc_valid_in = !d;
   tick(1);
   die_temp_valid_in = 1'b0;
   adc_valid_in = 1'b0;
   tick(3);
endtask
////////////////////////////////////////////////////////////////////////////////
task t_regs;
   rd(8'h3E, 8'hD1);
   rd(8'h40, 8'h00);
   rd(8'h41, 8'h3F);
   rd(8'h42, 8'h00);
   rd(8'h5B, 8'hFF);
   rd(8'h5C, 8'hFF);
   rd(8'h5D, 8'h00);
   wr(8'h3F, 8'h5A);
   rd(8'h3F, 8'h00);
   wr(8'h41, 8'hA5);
   wr(8'h42, 8'h9E);
   wr(8'h3E, 8'hE1);
   tick(1);
   chk({6'h0, precharge_current_out}, 8'h02);
   chk({3'h0, charge_target_voltage_out}, 8'h13);
   chk({5'h0, input_low_voltage_threshold_out}, 8'h06);
   chk({buck_low_power_out, buck_enable_out}, 2'h2);
   wr(8'h3E, 8'hD1);
   tick(1);
   chk({buck_low_power_out, buck_enable_out}, 2'h1);
   $display("test regs done");
endtask
task t_wall;
   wr(8'h40, 8'hA5);
   plug = 1'b1;
   wall_present_in = 1'b1;
   tick(3);
   rd(8'h3E, 8'hDA);
   wait_lim(4'hA);
   input_low_in = 1'b1;
   wait_lim(4'h0);
   input_low_in = 1'b0;
   wait_lim(4'hA);
   wall_present_in = 1'b0;
   plug = 1'b0;
   $display("test wall done");
endtask
task t_dminus;
   wr(8'h3E, 8'h93); // host turns autodetect off for a live phy
   kind = 2'h2;
   plug = 1'b1;
   tick(3);
   rd(8'h3E, 8'h95);
   kind = 2'h0;
   tick(3);
   wr(8'h3E, 8'h93);
   rd(8'h3E, 8'h93);
   plug = 1'b0;
   $display("test dminus done");
endtask
task t_detect;
   wr(8'h40, 8'hA7);
   wr(8'h3E, 8'hD2);
   kind = 2'h1;
   plug = 1'b1;
   tick(19);
   chk1(settings_load_out, 1'b0);
   for (n = 0; n < 8 && settings_load_out !== 1'b1; n = n + 1)
      tick(1);
   chk({settings_load_out, dplus_drive_out}, 2'h3);
   tick(3);
   rd(8'h3E, 8'hD7);
   plug = 1'b0;
   wr(8'h3E, 8'hD2);
   kind = 2'h0;
   plug = 1'b1;
   tick(30);
   rd(8'h3E, 8'hD2);
   $display("test detect done");
endtask
task t_batt;
   wr(8'h5B, 8'hC0);
   wr(8'h5C, 8'hA0);
   wr(8'h5D, 8'h40);
   sample(1'b0, 3'h2, 8'h80);
   chk1(charge_enable_out, 1'b1);
   sample(1'b0, 3'h2, 8'hC1);
   chk1(charge_enable_out, 1'b0);
   sample(1'b0, 3'h2, 8'hC0);
   chk1(charge_enable_out, 1'b0);
   sample(1'b0, 3'h2, 8'hA0);
   chk1(charge_enable_out, 1'b1);
   sample(1'b0, 3'h1, 8'hC1);
   chk1(charge_enable_out, 1'b1);
   sample(1'b0, 3'h2, 8'h3F);
   chk1(charge_enable_out, 1'b0);
   sample(1'b0, 3'h2, 8'h80);
   $display("test battery done");
endtask
task t_die;
   wr(8'h41, 8'h3F);
   sample(1'b1, 3'h0, 8'h5B);
   chk({2'h0, charge_current_out}, 8'h37);
   sample(1'b1, 3'h0, 8'h60);
   chk({2'h0, charge_current_out}, 8'h2D);
   sample(1'b1, 3'h0, 8'h6A);
   chk({2'h0, charge_current_out}, 8'h19);
   sample(1'b1, 3'h0, 8'h6F);
   chk({2'h0, charge_current_out}, 8'h0F);
   sample(1'b1, 3'h0, 8'h78);
   chk({1'h0, charge_enable_out, charge_current_out}, 8'h00);
   sample(1'b1, 3'h0, 8'h5F);
   chk({2'h0, charge_current_out}, 8'h00);
   wr(8'h3E, 8'h52);
   tick(1);
   chk({2'h0, charge_current_out}, 8'h3F);
   wr(8'h3E, 8'hD2);
   wr(8'h41, 8'h20);
   sample(1'b1, 3'h0, 8'h59);
   chk({2'h0, charge_current_out}, 8'h20);
   sample(1'b1, 3'h0, 8'h6A);
   chk({2'h0, charge_current_out}, 8'h19);
   $display("test die done");
endtask
task t_emerg;
   emerg_blink_en_in = 1'b1;
   for (i = 0; i < 4; i = i + 1)
   begin
      supply_fault_in = 1'b1;
      tick(1);
      supply_fault_in = 1'b0;
      tick(3);
      chk1(emergency_charge_out, i == 3);
   end
   chk1(auto_boot_block_out, 1'b1);
   seen = 2'h0;
   repeat (20)
   begin
      tick(1);
      seen = seen | {indicator_output_a_out, indicator_output_b_out};
   end
   chk({6'h0, seen}, 8'h03);
   battery_ok_in = 1'b1;
   tick(3);
   chk1(emergency_charge_out, 1'b0);
   $display("test emergency done");
endtask
task t_reset;
   rst_b_in = 1'b0;
   tick(2);
   chk({buck_enable_out, emergency_charge_out, charge_enable_out, 5'h00}, 8'h00);
   chk(reg_rdata_out, 8'h00);
   rst_b_in = 1'b1;
   rd(8'h3E, 8'hD1);
   rd(8'h41, 8'h3F);
   $display("test reset done");
endtask
////////////////////////////////////////////////////////////////////////////////
task print_verdict;
   $display("checks %0d mismatches %0d", num_checks, fail_count);
   if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
   else
      $display("TB: FAIL");
   $finish;
endtask
initial
begin
   #5000000;
   fail_count = fail_count + 1;
   print_verdict;
end
initial
begin
   tick(10);
   rst_b_in = 1'b1;
   t_regs;
   t_wall;
   t_dminus;
   t_detect;
   t_batt;
   t_die;
   t_emerg;
   t_reset;
   print_verdict;
end
endmodule
